// *** verilog/dcrm_pkg.sv ***
package dcrm_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CHANNELS = 32;
    localparam int GROUP_W = 16;
    localparam int TIMERS = 3;
    localparam int COUNT_W = 16;
    localparam int SWITCH_W = 4;

    // byte offsets from the selected I/O base
    localparam logic [3:0] OFF_PORT_A = 4'h0;
    localparam logic [3:0] OFF_PORT_B = 4'h1;
    localparam logic [3:0] OFF_PORT_C = 4'h2;
    localparam logic [3:0] OFF_PORT_D = 4'h3;
    localparam logic [3:0] OFF_TIMER0 = 4'h4;
    localparam logic [3:0] OFF_TIMER1 = 4'h5;
    localparam logic [3:0] OFF_TIMER2 = 4'h6;
    localparam logic [3:0] OFF_CONTROL = 4'h7;
    localparam logic [3:0] OFF_BOARD_ID = 4'h8;
    localparam logic [3:0] OFF_READBACK_A = 4'h9;
    localparam logic [3:0] OFF_READBACK_B = 4'hA;
    localparam logic [3:0] OFF_READBACK_C = 4'hB;
    localparam logic [3:0] OFF_READBACK_D = 4'hC;

    // control byte field codes
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;
    localparam logic [1:0] SEL_ILLEGAL = 2'h3;

    localparam logic [31:0] DOUT_RESET = 32'h0000_0000;
    localparam logic [7:0] NO_DATA = 8'h00;
    localparam logic [15:0] GROUP_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    typedef struct packed {
        logic [1:0] select;
        logic [1:0] access;
        logic [2:0] mode;
        logic bcd;
    } dcrm_ctrl_t;

    localparam dcrm_ctrl_t CTRL_RESET = 8'h10;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] data;
    } dcrm_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dcrm_rsp_t;

    typedef enum logic [1:0] {
        PHASE_LOW = 2'b01,
        PHASE_HIGH = 2'b10
    } dcrm_phase_t;

endpackage

// *** verilog/dcrm_strobe_latch.sv ***
`timescale 1ns/10ps
module dcrm_strobe_latch (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [dcrm_pkg::GROUP_W-1:0] pinData,
    input wire logic pinStrobe,
    output logic [dcrm_pkg::GROUP_W-1:0] groupData
);
    import dcrm_pkg::*;

    logic [GROUP_W-1:0] dataMeta_reg;
    logic [GROUP_W-1:0] dataSync_reg;
    logic strobeMeta_reg;
    logic strobeSync_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dataMeta_reg <= GROUP_RESET;
            dataSync_reg <= GROUP_RESET;
            strobeMeta_reg <= 1'b1;
            strobeSync_reg <= 1'b1;
        end else begin
            dataMeta_reg <= pinData;
            dataSync_reg <= dataMeta_reg;
            strobeMeta_reg <= pinStrobe;
            strobeSync_reg <= strobeMeta_reg;
        end
    end

    // last sample taken while strobe was high is what stays held
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            groupData <= GROUP_RESET;
        end else if (strobeSync_reg) begin
            groupData <= dataSync_reg;
        end
    end

    held_while_low_a: assert property (@(posedge sys_clk) disable iff (reset)
        !strobeSync_reg |=> $stable(groupData))
        else $error("input group changed while strobe low");

endmodule

// *** verilog/dcrm_top.sv ***
`timescale 1ns/10ps
// Behaviour
// - decode thirteen byte registers at offsets 0 to 12, ignore all others
// - offset 0 read returns input channels 0-7, bit n is channel n
// - offset 0 write sets output channels 0-7, bit n is channel n
// - offsets 1-3 read input channels 8-15, 16-23, 24-31, lowest in bit 0
// - offsets 1-3 write output channels 8-15, 16-23, 24-31, lowest in bit 0
// - offsets 4-6 move one count byte of timers 0-2, chosen by control byte
// - offset 7 takes control byte writes, nothing readable there
// - offset 8 reads board identifier, writes there do nothing
// - offsets 9-12 read back latched output bytes, read only
// - bit 0 is least significant, channels ascend from it
// - strobe high gives live inputs, falling edge latches group while low
// - identifier follows switches, switch on reads 1, default zero
module dcrm_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire dcrm_pkg::dcrm_req_t hostReq,
    output dcrm_pkg::dcrm_rsp_t hostRsp,
    input wire logic [dcrm_pkg::CHANNELS-1:0] digitalIn,
    input wire logic [1:0] inputStrobe,
    input wire logic [dcrm_pkg::SWITCH_W-1:0] boardIdSwitch,
    output logic [dcrm_pkg::CHANNELS-1:0] digitalOut,
    input wire logic [dcrm_pkg::TIMERS-1:0][dcrm_pkg::COUNT_W-1:0] timerLiveCount,
    output dcrm_pkg::dcrm_ctrl_t [dcrm_pkg::TIMERS-1:0] timerCtrl,
    output logic [dcrm_pkg::TIMERS-1:0] timerModeSet,
    output logic [dcrm_pkg::TIMERS-1:0][dcrm_pkg::COUNT_W-1:0] timerLoadValue,
    output logic [dcrm_pkg::TIMERS-1:0] timerLoadPulse
);
    import dcrm_pkg::*;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    logic [GROUP_W-1:0] groupLow;
    logic [GROUP_W-1:0] groupHigh;
    logic [SWITCH_W-1:0] switchMeta_reg;
    logic [SWITCH_W-1:0] switchSync_reg;
    logic writeHit;
    logic readHit;
    dcrm_ctrl_t ctrlByte;
    logic [TIMERS-1:0] countWrite;
    logic [TIMERS-1:0] countRead;
    logic [TIMERS-1:0] latchCmd;
    logic [TIMERS-1:0] modeCmd;
    logic [TIMERS-1:0][DATA_W-1:0] countReadByte;
    logic [DATA_W-1:0] readByte;

    // one latch per connector, each with its own strobe
    dcrm_strobe_latch lowGroup (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinData(digitalIn[15:0]),
        .pinStrobe(inputStrobe[0]),
        .groupData(groupLow)
    );

    dcrm_strobe_latch highGroup (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinData(digitalIn[31:16]),
        .pinStrobe(inputStrobe[1]),
        .groupData(groupHigh)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            switchMeta_reg <= '0;
            switchSync_reg <= '0;
        end else begin
            switchMeta_reg <= boardIdSwitch;
            switchSync_reg <= switchMeta_reg;
        end
    end

    // offsets above 12 fall outside the block and are dropped
    assign writeHit = hostReq.wr && (hostReq.addr <= OFF_READBACK_D);
    assign readHit = hostReq.rd && (hostReq.addr <= OFF_READBACK_D);
    assign ctrlByte = hostReq.data;

    // output latches, bit n of each byte drives the nth channel of its group
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            digitalOut <= DOUT_RESET;
        end else if (writeHit) begin
            case (hostReq.addr)
                OFF_PORT_A: digitalOut[7:0] <= hostReq.data;
                OFF_PORT_B: digitalOut[15:8] <= hostReq.data;
                OFF_PORT_C: digitalOut[23:16] <= hostReq.data;
                OFF_PORT_D: digitalOut[31:24] <= hostReq.data;
                default: digitalOut <= digitalOut;
            endcase
        end
    end

    generate
        for (genvar ch = 0; ch < TIMERS; ch++) begin : gTimer
            logic [COUNT_W-1:0] snapshot_reg;
            logic snapshotValid_reg;
            logic [DATA_W-1:0] loadLow_reg;
            dcrm_phase_t writePhase_reg;
            dcrm_phase_t readPhase_reg;
            logic [COUNT_W-1:0] readSource;
            logic readHigh;
            logic readDone;

            assign countWrite[ch] = writeHit && (hostReq.addr == OFF_TIMER0 + 4'(ch));
            assign countRead[ch] = readHit && (hostReq.addr == OFF_TIMER0 + 4'(ch));
            assign modeCmd[ch] = writeHit && (hostReq.addr == OFF_CONTROL)
                && (ctrlByte.select == 2'(ch)) && (ctrlByte.access != ACC_LATCH);
            assign latchCmd[ch] = writeHit && (hostReq.addr == OFF_CONTROL)
                && (ctrlByte.select == 2'(ch)) && (ctrlByte.access == ACC_LATCH);

            // a latched snapshot wins over the live count until fully read or a mode write clears it
            assign readSource = snapshotValid_reg ? snapshot_reg : timerLiveCount[ch];
            always_comb begin
                case (timerCtrl[ch].access)
                    ACC_HIGH: readHigh = 1'b1;
                    ACC_BOTH: readHigh = (readPhase_reg == PHASE_HIGH);
                    default: readHigh = 1'b0;
                endcase
            end
            assign countReadByte[ch] = readHigh ? readSource[15:8] : readSource[7:0];
            assign readDone = countRead[ch]
                && ((timerCtrl[ch].access != ACC_BOTH) || (readPhase_reg == PHASE_HIGH));

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    timerCtrl[ch] <= CTRL_RESET;
                    timerModeSet[ch] <= 1'b0;
                end else begin
                    timerModeSet[ch] <= modeCmd[ch];
                    if (modeCmd[ch]) begin
                        timerCtrl[ch] <= ctrlByte;
                    end
                end
            end

            // counter latch freezes the count; a second latch before the read is ignored
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    snapshot_reg <= COUNT_RESET;
                    snapshotValid_reg <= 1'b0;
                end else if (modeCmd[ch]) begin
                    snapshotValid_reg <= 1'b0;
                end else if (latchCmd[ch] && !snapshotValid_reg) begin
                    snapshot_reg <= timerLiveCount[ch];
                    snapshotValid_reg <= 1'b1;
                end else if (readDone) begin
                    snapshotValid_reg <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    readPhase_reg <= PHASE_LOW;
                end else if (modeCmd[ch]) begin
                    readPhase_reg <= PHASE_LOW;
                end else if (countRead[ch] && timerCtrl[ch].access == ACC_BOTH) begin
                    case (readPhase_reg)
                        PHASE_LOW: readPhase_reg <= PHASE_HIGH;
                        PHASE_HIGH: readPhase_reg <= PHASE_LOW;
                        default: readPhase_reg <= PHASE_LOW;
                    endcase
                end
            end

            // two-byte loads hand the count on only after the high byte
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    writePhase_reg <= PHASE_LOW;
                    loadLow_reg <= NO_DATA;
                    timerLoadValue[ch] <= COUNT_RESET;
                    timerLoadPulse[ch] <= 1'b0;
                end else begin
                    timerLoadPulse[ch] <= 1'b0;
                    if (modeCmd[ch]) begin
                        writePhase_reg <= PHASE_LOW;
                    end else if (countWrite[ch]) begin
                        case (timerCtrl[ch].access)
                            ACC_LOW: begin
                                timerLoadValue[ch] <= {8'h00, hostReq.data};
                                timerLoadPulse[ch] <= 1'b1;
                            end
                            ACC_HIGH: begin
                                timerLoadValue[ch] <= {hostReq.data, 8'h00};
                                timerLoadPulse[ch] <= 1'b1;
                            end
                            ACC_BOTH: begin
                                case (writePhase_reg)
                                    PHASE_LOW: begin
                                        loadLow_reg <= hostReq.data;
                                        writePhase_reg <= PHASE_HIGH;
                                    end
                                    PHASE_HIGH: begin
                                        timerLoadValue[ch] <= {hostReq.data, loadLow_reg};
                                        timerLoadPulse[ch] <= 1'b1;
                                        writePhase_reg <= PHASE_LOW;
                                    end
                                    default: writePhase_reg <= PHASE_LOW;
                                endcase
                            end
                            default: writePhase_reg <= writePhase_reg;
                        endcase
                    end
                end
            end
        end
    endgenerate

    // read data multiplexer
    always_comb begin
        case (hostReq.addr)
            OFF_PORT_A: readByte = groupLow[7:0];
            OFF_PORT_B: readByte = groupLow[15:8];
            OFF_PORT_C: readByte = groupHigh[7:0];
            OFF_PORT_D: readByte = groupHigh[15:8];
            OFF_TIMER0: readByte = countReadByte[0];
            OFF_TIMER1: readByte = countReadByte[1];
            OFF_TIMER2: readByte = countReadByte[2];
            OFF_BOARD_ID: readByte = {4'h0, switchSync_reg};
            OFF_READBACK_A: readByte = digitalOut[7:0];
            OFF_READBACK_B: readByte = digitalOut[15:8];
            OFF_READBACK_C: readByte = digitalOut[23:16];
            OFF_READBACK_D: readByte = digitalOut[31:24];
            default: readByte = NO_DATA;
        endcase
    end

    // every read gets an answer, out-of-range ones read as zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hostRsp <= '0;
        end else begin
            hostRsp.valid <= hostReq.rd;
            if (hostReq.rd) begin
                hostRsp.data <= readHit ? readByte : NO_DATA;
            end
        end
    end

    sequence rd_at(logic [3:0] off);
        hostReq.rd && !hostReq.wr && hostReq.addr == off;
    endsequence

    port_a_write_a: assert property (
        hostReq.wr && hostReq.addr == OFF_PORT_A |=> digitalOut[7:0] == $past(hostReq.data))
        else $error("port A write not applied");

    port_d_write_a: assert property (
        hostReq.wr && hostReq.addr == OFF_PORT_D |=> digitalOut[31:24] == $past(hostReq.data))
        else $error("port D write not applied");

    input_read_a: assert property (
        rd_at(OFF_PORT_A) |=> hostRsp.valid && hostRsp.data == $past(groupLow[7:0]))
        else $error("port A read wrong");

    high_group_read_a: assert property (
        rd_at(OFF_PORT_D) |=> hostRsp.data == $past(groupHigh[15:8]))
        else $error("port D read wrong");

    readback_a: assert property (
        rd_at(OFF_READBACK_B) |=> hostRsp.data == $past(digitalOut[15:8]))
        else $error("readback B wrong");

    board_id_a: assert property (
        rd_at(OFF_BOARD_ID) |=> hostRsp.data == {4'h0, $past(switchSync_reg)})
        else $error("board identifier read wrong");

    unmapped_read_a: assert property (
        hostReq.rd && hostReq.addr > OFF_READBACK_D |=> hostRsp.valid && hostRsp.data == NO_DATA)
        else $error("unmapped read not zero");

    readonly_write_a: assert property (
        hostReq.wr && hostReq.addr >= OFF_BOARD_ID |=> $stable(digitalOut) && $stable(timerCtrl))
        else $error("read-only write changed state");

    control_write_a: assert property (
        hostReq.wr && hostReq.addr == OFF_CONTROL && hostReq.data[7:6] == 2'h1
            && hostReq.data[5:4] != ACC_LATCH
        |=> timerModeSet[1] && timerCtrl[1] == $past(hostReq.data))
        else $error("control byte not taken");

    two_byte_load_a: assert property (
        timerCtrl[0].access == ACC_BOTH && !modeCmd[0] && countWrite[0]
            && gTimer[0].writePhase_reg == PHASE_HIGH
        |=> timerLoadPulse[0] && timerLoadValue[0][15:8] == $past(hostReq.data))
        else $error("two-byte load not completed");

    sequence wr_at(logic [3:0] off);
        hostReq.wr && !hostReq.rd && hostReq.addr == off;
    endsequence

    port_b_write_a: assert property (
        wr_at(OFF_PORT_B) |=> digitalOut[15:8] == $past(hostReq.data))
        else $error("port B write not applied");

    port_c_write_a: assert property (
        wr_at(OFF_PORT_C) |=> digitalOut[23:16] == $past(hostReq.data))
        else $error("port C write not applied");

    port_b_read_a: assert property (
        rd_at(OFF_PORT_B) |=> hostRsp.data == $past(groupLow[15:8]))
        else $error("port B read wrong");

    port_c_read_a: assert property (
        rd_at(OFF_PORT_C) |=> hostRsp.data == $past(groupHigh[7:0]))
        else $error("port C read wrong");

    readback_first_a: assert property (
        rd_at(OFF_READBACK_A) |=> hostRsp.data == $past(digitalOut[7:0]))
        else $error("readback A wrong");

    readback_last_a: assert property (
        rd_at(OFF_READBACK_D) |=> hostRsp.data == $past(digitalOut[31:24]))
        else $error("readback D wrong");

    control_read_a: assert property (
        rd_at(OFF_CONTROL) |=> hostRsp.valid && hostRsp.data == NO_DATA)
        else $error("control location read not empty");

    response_pulse_a: assert property (
        1'b1 |=> hostRsp.valid == $past(hostReq.rd))
        else $error("read response pulse wrong");

    readonly_pulse_a: assert property (
        hostReq.wr && hostReq.addr >= OFF_BOARD_ID
        |=> timerModeSet == '0 && timerLoadPulse == '0)
        else $error("read-only write started a timer action");

    latch_no_mode_a: assert property (
        hostReq.wr && hostReq.addr == OFF_CONTROL && hostReq.data[5:4] == ACC_LATCH
        |=> timerModeSet == '0 && $stable(timerCtrl))
        else $error("latch command changed a timer mode");

    illegal_select_a: assert property (
        hostReq.wr && hostReq.addr == OFF_CONTROL && hostReq.data[7:6] == SEL_ILLEGAL
        |=> timerModeSet == '0 && $stable(timerCtrl))
        else $error("illegal select changed a timer");

    low_load_a: assert property (
        timerCtrl[0].access == ACC_LOW && countWrite[0]
        |=> timerLoadPulse[0] && timerLoadValue[0] == {8'h00, $past(hostReq.data)})
        else $error("low byte load wrong");

    first_byte_hold_a: assert property (
        timerCtrl[1].access == ACC_BOTH && countWrite[1]
            && gTimer[1].writePhase_reg == PHASE_LOW
        |=> !timerLoadPulse[1])
        else $error("load handed on after first byte");

    snapshot_take_a: assert property (
        latchCmd[0] && !gTimer[0].snapshotValid_reg
        |=> gTimer[0].snapshotValid_reg && gTimer[0].snapshot_reg == $past(timerLiveCount[0]))
        else $error("latch command did not freeze count");

endmodule

// *** verification/dcrm_host_model.sv ***
`timescale 1ns/10ps
module dcrm_host_model (
    input wire logic sys_clk,
    output dcrm_pkg::dcrm_req_t hostReq,
    input wire dcrm_pkg::dcrm_rsp_t hostRsp
);
    import dcrm_pkg::*;
    logic rspSeen;
    initial begin
        hostReq = '0;
        rspSeen = 1'b0;
    end
    // request changes at the falling edge so the taking rising edge sees it settled
    task automatic write_byte(input logic [3:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        hostReq.addr = addr;
        hostReq.data = data;
        hostReq.wr = 1'b1;
        @(negedge sys_clk);
        hostReq.wr = 1'b0;
        // released bus must not keep the old byte
        hostReq.data = ~data;
    endtask
    task automatic read_byte(input logic [3:0] addr, output logic [7:0] data);
        @(negedge sys_clk);
        hostReq.addr = addr;
        hostReq.rd = 1'b1;
        // answer stands only from the taking edge to the next one, so look midway
        @(negedge sys_clk);
        rspSeen = hostRsp.valid;
        data = hostRsp.data;
        hostReq.rd = 1'b0;
    endtask
    // low byte first, then high, as the access field asks
    task automatic read_count(input logic [3:0] addr, output logic [15:0] count);
        logic [7:0] lo;
        logic [7:0] hi;
        read_byte(addr, lo);
        read_byte(addr, hi);
        count = {hi, lo};
    endtask
endmodule

// *** verification/dcrm_top_bench.sv ***
`timescale 1ns/10ps
module dcrm_top_bench;
    import dcrm_pkg::*;
    logic sys_clk;
    logic reset;
    dcrm_req_t hostReq;
    dcrm_rsp_t hostRsp;
    logic [31:0] digitalIn;
    logic [1:0] inputStrobe;
    logic [3:0] boardIdSwitch;
    logic [31:0] digitalOut;
    logic [2:0][15:0] timerLiveCount;
    dcrm_ctrl_t [2:0] timerCtrl;
    logic [2:0] timerModeSet;
    logic [2:0][15:0] timerLoadValue;
    logic [2:0] timerLoadPulse;
    int miscompares;
    int checks;
    logic [31:0] pattern;
    logic [15:0] cnt;
    logic [15:0] got;
    logic [3:0] addr;

    dcrm_top u_dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .hostReq(hostReq),
        .hostRsp(hostRsp),
        .digitalIn(digitalIn),
        .inputStrobe(inputStrobe),
        .boardIdSwitch(boardIdSwitch),
        .digitalOut(digitalOut),
        .timerLiveCount(timerLiveCount),
        .timerCtrl(timerCtrl),
        .timerModeSet(timerModeSet),
        .timerLoadValue(timerLoadValue),
        .timerLoadPulse(timerLoadPulse)
    );

    dcrm_host_model u_host (
        .sys_clk(sys_clk),
        .hostReq(hostReq),
        .hostRsp(hostRsp)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic compare(input string what, input logic [31:0] expected,
            input logic [31:0] seen);
        checks++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic read_check(input logic [3:0] a, input logic [7:0] expected);
        logic [7:0] data;
        u_host.read_byte(a, data);
        compare("response valid", 32'h1, {31'h0, u_host.rspSeen});
        compare($sformatf("read offset %0d", a), {24'h0, expected}, {24'h0, data});
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // whole sequence needs a few hundred cycles at most
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    initial begin
        miscompares = 0;
        checks = 0;
        reset = 1'b1;
        digitalIn = 32'h0;
        inputStrobe = 2'b11;
        boardIdSwitch = 4'h0;
        timerLiveCount = '0;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        compare("outputs after reset", 32'h0, digitalOut);
        compare("control after reset", {8'h0, CTRL_RESET, CTRL_RESET, CTRL_RESET},
            {8'h0, timerCtrl});
        compare("pulses after reset", 32'h0, {26'h0, timerModeSet, timerLoadPulse});
        pattern = 32'hC3A5_5A81;
        for (int i = 0; i < 4; i++) begin
            u_host.write_byte(4'(i), pattern[8*i +: 8]);
        end
        compare("output pins", pattern, digitalOut);
        for (int i = 0; i < 4; i++) begin
            read_check(4'(9 + i), pattern[8*i +: 8]);
        end
        for (int i = 8; i < 16; i++) begin
            u_host.write_byte(4'(i), 8'hFF);
        end
        compare("outputs after ignored writes", pattern, digitalOut);
        read_check(OFF_READBACK_D, pattern[31:24]);
        read_check(OFF_BOARD_ID, 8'h00);
        read_check(OFF_CONTROL, NO_DATA);
        for (int i = 13; i < 16; i++) begin
            read_check(4'(i), NO_DATA);
        end
        digitalIn = 32'h3C96_E10F;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            read_check(4'(i), digitalIn[8*i +: 8]);
        end
        pattern = digitalIn;
        inputStrobe = 2'b00;
        repeat (4) @(negedge sys_clk);
        digitalIn = ~pattern;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            read_check(4'(i), pattern[8*i +: 8]);
        end
        @(negedge sys_clk);
        inputStrobe = 2'b01;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            read_check(4'(i), (i < 2) ? ~pattern[8*i +: 8] : pattern[8*i +: 8]);
        end
        @(negedge sys_clk);
        inputStrobe = 2'b11;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            boardIdSwitch = 4'(i * 5);
            repeat (3) @(negedge sys_clk);
            read_check(OFF_BOARD_ID, {4'h0, 4'(i * 5)});
        end
        for (int t = 0; t < 3; t++) begin
            addr = 4'(4 + t);
            u_host.write_byte(OFF_CONTROL, {2'(t), ACC_BOTH, 3'h0, 1'b0});
            compare("mode set pulse", 32'h1 << t, {29'h0, timerModeSet});
            compare("control byte", {24'h0, 2'(t), ACC_BOTH, 4'h0},
                {24'h0, timerCtrl[t]});
            u_host.write_byte(addr, 8'h21 + 8'(t));
            compare("load pulse early", 32'h0, {29'h0, timerLoadPulse});
            u_host.write_byte(addr, 8'hB0 + 8'(t));
            compare("load pulse", 32'h1 << t, {29'h0, timerLoadPulse});
            compare("load value", {16'h0, 8'hB0 + 8'(t), 8'h21 + 8'(t)},
                {16'h0, timerLoadValue[t]});
            cnt = 16'h4E21 + 16'h0101 * 16'(t);
            timerLiveCount[t] = cnt;
            u_host.read_count(addr, got);
            compare("live count", {16'h0, cnt}, {16'h0, got});
            u_host.write_byte(OFF_CONTROL, {2'(t), ACC_LATCH, 4'h0});
            compare("no mode set on latch", 32'h0, {29'h0, timerModeSet});
            timerLiveCount[t] = ~cnt;
            u_host.read_count(addr, got);
            compare("latched count", {16'h0, cnt}, {16'h0, got});
            u_host.write_byte(OFF_CONTROL, {2'(t), ACC_LOW, 4'h0});
            u_host.write_byte(addr, 8'h5A);
            compare("low only load", {15'h0, 1'b1, 16'h005A},
                {15'h0, timerLoadPulse[t], timerLoadValue[t]});
            u_host.write_byte(OFF_CONTROL, {2'(t), ACC_HIGH, 4'h0});
            u_host.write_byte(addr, 8'hA5);
            compare("high only load", {15'h0, 1'b1, 16'hA500},
                {15'h0, timerLoadPulse[t], timerLoadValue[t]});
        end
        // select code 3 must not disturb any timer
        u_host.write_byte(OFF_CONTROL, {SEL_ILLEGAL, ACC_BOTH, 4'h0});
        compare("mode set on bad select", 32'h0, {29'h0, timerModeSet});
        compare("controls kept", 32'h00A0_6020, {8'h0, timerCtrl});
        read_check(OFF_READBACK_A, 8'h81);
        complete_run();
    end
endmodule
